/* wdt_params.svh */
// constants for the watchdog: offsets, fields, reset values and counts
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
`define WDT_PRE_W        12
`define WDT_CNT_W        6
`define WDT_CNT_MAX      6'h3f
`define WDT_SHORT_MSB    6
`define WDT_KEEP_LO      4
`define WDT_PULSE_CYC    32
`define WDT_PULSE_LAST   6'h1f
`define WDT_POR_CYC      4096
`define WDT_POR_LAST     12'hfff
`define WDT_ADDR_W       18
`define WDT_IDX_W        16
`define WDT_IDX_SERVICE  16'hffff
`define WDT_IDX_CFG      16'h0000
`define WDT_IDX_CAUSE    16'h0001
`define WDT_IDX_IRQ_STAT 16'h0002
`define WDT_IDX_IRQ_CLR  16'h0003
`define WDT_IDX_IRQ_EN   16'h0004
`define WDT_IDX_STATE    16'h0005
`define WDT_CFG_DIS      0
`define WDT_CFG_LONG     1
`define WDT_CFG_RST      2'h0
`define WDT_CAUSE_WDT    0
`define WDT_IRQ_TIMEOUT  0
`define WDT_IRQ_SERVICE  1
`define WDT_IRQ_W        2
`endif

/* wdt_pkg.sv */
// types shared by the watchdog modules
package wdt_pkg;
  // gray along idle -> hold -> done
  typedef enum logic [1:0] {
    WDT_PS_IDLE = 2'b00,
    WDT_PS_HOLD = 2'b01,
    WDT_PS_DONE = 2'b11
  } wdt_pulse_state_t;
endpackage

/* wdt_tick_if.sv */
// prescaler to counter link of the watchdog
`timescale 1ns/1ps
`include "wdt_params.svh"
interface wdt_tick_if;
  logic                  run;
  logic                  clr_all;
  logic                  clr_upper;
  logic                  long_sel;
  logic                  tick;
  logic [`WDT_PRE_W-1:0] pre;
  modport prescaler (input run, input clr_all, input clr_upper, input long_sel,
                     output tick, output pre);
  modport counter   (output run, output clr_all, output clr_upper, output long_sel,
                     input tick, input pre);
endinterface

/* wdt_prescaler.sv */
// 12-bit watchdog prescaler with terminal count tick
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_prescaler (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  wdt_tick_if.prescaler tk
);
  logic [`WDT_PRE_W-1:0] pre_q;

  // full clear wins over the partial service clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre_q <= '0;
    end else if (i_ce) begin
      if (tk.clr_all) begin
        pre_q <= '0;
      end else if (tk.clr_upper) begin
        pre_q <= {{(`WDT_PRE_W-`WDT_KEEP_LO){1'b0}}, pre_q[`WDT_KEEP_LO-1:0]};
      end else if (tk.run) begin
        pre_q <= pre_q + 12'h001;
      end
    end
  end

  // terminal count: 2^7 or 2^12 crystal cycles per counter step
  assign tk.tick = i_ce && tk.run && !tk.clr_all && !tk.clr_upper &&
                   (tk.long_sel ? (&pre_q) : (&pre_q[`WDT_SHORT_MSB:0]));
  assign tk.pre  = pre_q;
endmodule // wdt_prescaler

/* wdt_rst_pulse.sv */
// stretches a watchdog overflow into a 32-cycle low on the reset pin
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_rst_pulse (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_pin_oe
);
  wdt_pkg::wdt_pulse_state_t st_q;
  logic [`WDT_CNT_W-1:0]     cnt_q;

  // pin is pulled low only while holding
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q  <= wdt_pkg::WDT_PS_IDLE;
      cnt_q <= '0;
    end else if (i_ce) begin
      case (st_q)
        wdt_pkg::WDT_PS_IDLE: begin
          cnt_q <= '0;
          if (i_start) st_q <= wdt_pkg::WDT_PS_HOLD;
        end
        wdt_pkg::WDT_PS_HOLD: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == `WDT_PULSE_LAST) st_q <= wdt_pkg::WDT_PS_DONE;
        end
        wdt_pkg::WDT_PS_DONE: st_q <= wdt_pkg::WDT_PS_IDLE;
        default:              st_q <= wdt_pkg::WDT_PS_IDLE;
      endcase
    end
  end

  assign o_pin_oe = (st_q == wdt_pkg::WDT_PS_HOLD);
  assign o_busy   = (st_q != wdt_pkg::WDT_PS_IDLE);

  property p_pulse_len;
    @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    $rose(o_pin_oe) |-> (cnt_q == 6'h00) ##31 (o_pin_oe && cnt_q == 6'h1f) ##1 !o_pin_oe;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pin low not 32 cycles");
endmodule // wdt_rst_pulse

/* wdt_top.sv */
// watchdog timeout reset block with APB registers
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_top (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_ce,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`WDT_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  input  wire logic [7:0]             i_reset_vector_lo,
  input  wire logic                   i_monitor_mode,
  input  wire logic                   i_break_state,
  input  wire logic                   i_rst_pin_hv,
  input  wire logic                   i_irq_pin_hv,
  input  wire logic                   i_stop_exec,
  input  wire logic                   i_stop_mode,
  input  wire logic                   i_internal_reset,
  input  wire logic                   i_vector_fetch,
  input  wire logic                   i_rst_pin_i,
  output logic                        o_rst_pin_o,
  output logic                        o_rst_pin_oe,
  output logic                        o_sys_rst_req,
  output logic                        o_irq
);
  // register word hit: index times four, word aligned
  function automatic logic hit(input logic [`WDT_ADDR_W-1:0] a,
                               input logic [`WDT_IDX_W-1:0]  idx);
    hit = (a[`WDT_ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic known(input logic [`WDT_ADDR_W-1:0] a);
    known = hit(a, `WDT_IDX_SERVICE) || hit(a, `WDT_IDX_CFG) ||
            hit(a, `WDT_IDX_CAUSE) || hit(a, `WDT_IDX_IRQ_STAT) ||
            hit(a, `WDT_IDX_IRQ_CLR) || hit(a, `WDT_IDX_IRQ_EN) ||
            hit(a, `WDT_IDX_STATE);
  endfunction

  wdt_tick_if tk ();

  logic [1:0]                  cfg_q;
  logic [`WDT_CNT_W-1:0]       cnt_q;
  logic [0:0]                  cause_q;
  logic [`WDT_IRQ_W-1:0]       irq_stat_q;
  logic [`WDT_IRQ_W-1:0]       irq_en_q;
  logic [`WDT_PRE_W-1:0]       por_cnt_q;
  logic                        por_done_q;
  logic [1:0]                  hv_rst_s_q;
  logic [1:0]                  hv_irq_s_q;
  logic [1:0]                  pin_s_q;
  logic [31:0]                 prdata_q;
  logic                        pready_q;
  logic                        pslverr_q;
  logic                        sys_rst_q;
  logic                        irq_q;
  logic                        pin_oe_q;
  logic                        setup;
  logic                        access;
  logic                        wr_done;
  logic                        svc_wr;
  logic                        disabled;
  logic                        overflow;
  logic                        por_clr;
  logic                        pulse_busy;
  logic                        pulse_oe;
  logic                        hv_rst;
  logic                        hv_irq;

  // pin inputs pass two flops; only the second stage is read
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hv_rst_s_q <= 2'h0;
      hv_irq_s_q <= 2'h0;
      pin_s_q    <= 2'h0;
    end else if (i_ce) begin
      hv_rst_s_q <= {hv_rst_s_q[0], i_rst_pin_hv};
      hv_irq_s_q <= {hv_irq_s_q[0], i_irq_pin_hv};
      pin_s_q    <= {pin_s_q[0], i_rst_pin_i};
    end
  end
  assign hv_rst = hv_rst_s_q[1];
  assign hv_irq = hv_irq_s_q[1];

  // apb phases; one wait-free access phase
  assign setup   = i_psel && !i_penable;
  assign access  = i_psel && i_penable;
  assign wr_done = access && pready_q && i_pwrite && !pslverr_q;
  assign svc_wr  = wr_done && hit(i_paddr, `WDT_IDX_SERVICE);

  // disable sources: config bit or test voltage in monitor or break state
  assign disabled = cfg_q[`WDT_CFG_DIS] ||
                    (i_monitor_mode && (hv_rst || hv_irq)) ||
                    (i_break_state && hv_rst);

  // power-on clear of the prescaler after 4096 crystal cycles
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      por_cnt_q  <= 12'h000;
      por_done_q <= 1'b0;
    end else if (i_ce && !por_done_q) begin
      por_cnt_q <= por_cnt_q + 12'h001;
      if (por_cnt_q == `WDT_POR_LAST) por_done_q <= 1'b1;
    end
  end
  assign por_clr = !por_done_q && (por_cnt_q == `WDT_POR_LAST);

  // prescaler control; stop mode gates the crystal clock off (wait mode does not)
  assign tk.run       = !i_stop_mode && !disabled;
  assign tk.clr_all   = disabled || i_internal_reset ||
                        i_stop_exec || i_stop_mode ||
                        por_clr || i_vector_fetch ||
                        pulse_busy;
  assign tk.clr_upper = svc_wr;
  assign tk.long_sel  = cfg_q[`WDT_CFG_LONG];

  wdt_prescaler u_pre (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .tk      (tk)
  );

  // 6-bit counter steps once per prescaler terminal count
  assign overflow = tk.tick && (cnt_q == `WDT_CNT_MAX) && !pulse_busy;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (i_ce) begin
      if (disabled || i_internal_reset || svc_wr || pulse_busy) begin
        cnt_q <= '0;
      end else if (tk.tick) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  // overflow: system reset request pulse and pin stretch
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sys_rst_q <= 1'b0;
      pin_oe_q  <= 1'b0;
    end else if (i_ce) begin
      sys_rst_q <= overflow;
      pin_oe_q  <= pulse_oe;
    end
  end

  wdt_rst_pulse u_pulse (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_ce     (i_ce),
    .i_start  (sys_rst_q),
    .o_busy   (pulse_busy),
    .o_pin_oe (pulse_oe)
  );

  // configuration bits; cleared by the block reset, freely rewritable over APB
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_q <= `WDT_CFG_RST;
    end else if (i_ce && wr_done && hit(i_paddr, `WDT_IDX_CFG)) begin
      cfg_q <= i_pwdata[1:0];
    end
  end

  // reset cause: set by overflow, write one to clear, set wins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cause_q <= 1'b0;
    end else if (i_ce) begin
      if (sys_rst_q) begin
        cause_q[`WDT_CAUSE_WDT] <= 1'b1;
      end else if (wr_done && hit(i_paddr, `WDT_IDX_CAUSE) && i_pwdata[`WDT_CAUSE_WDT]) begin
        cause_q[`WDT_CAUSE_WDT] <= 1'b0;
      end
    end
  end

  // event status and enable; o_irq is a registered summary line,
  // high while any enabled status bit is set, timeout included
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_stat_q <= '0;
      irq_en_q   <= '0;
      irq_q      <= 1'b0;
    end else if (i_ce) begin
      for (int b = 0; b < `WDT_IRQ_W; b++) begin
        if ((b == `WDT_IRQ_TIMEOUT && sys_rst_q) || (b == `WDT_IRQ_SERVICE && svc_wr)) begin
          irq_stat_q[b] <= 1'b1;
        end else if (wr_done && hit(i_paddr, `WDT_IDX_IRQ_CLR) && i_pwdata[b]) begin
          irq_stat_q[b] <= 1'b0;
        end
      end
      if (wr_done && hit(i_paddr, `WDT_IDX_IRQ_EN)) irq_en_q <= i_pwdata[`WDT_IRQ_W-1:0];
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  // read data captured in the setup phase, so it comes from a flop
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (i_ce) begin
      pready_q  <= setup;
      pslverr_q <= setup && !known(i_paddr);
      if (setup && !i_pwrite) begin
        prdata_q <= 32'h0000_0000;
        if (hit(i_paddr, `WDT_IDX_SERVICE)) prdata_q <= {24'h0, i_reset_vector_lo};
        if (hit(i_paddr, `WDT_IDX_CFG))      prdata_q <= {30'h0, cfg_q};
        if (hit(i_paddr, `WDT_IDX_CAUSE))    prdata_q <= {31'h0, cause_q};
        if (hit(i_paddr, `WDT_IDX_IRQ_STAT)) prdata_q <= {30'h0, irq_stat_q};
        if (hit(i_paddr, `WDT_IDX_IRQ_EN))   prdata_q <= {30'h0, irq_en_q};
        if (hit(i_paddr, `WDT_IDX_STATE))
          prdata_q <= {8'h0, pin_s_q[1], disabled, pulse_busy, 1'b0, tk.pre, 2'h0, cnt_q};
      end
    end
  end

  assign o_prdata      = prdata_q;
  assign o_pready      = pready_q;
  assign o_pslverr     = pslverr_q;
  assign o_sys_rst_req = sys_rst_q;
  assign o_rst_pin_oe  = pin_oe_q;
  assign o_rst_pin_o   = 1'b0 & pin_oe_q;
  assign o_irq         = irq_q;

  // checks
  property p_overflow_req;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && overflow) |=> o_sys_rst_req;
  endproperty
  a_overflow_req: assert property (p_overflow_req) else $error("overflow gave no reset request");

  property p_long_tick;
    @(posedge i_clk) disable iff (!i_rst_n)
    (tk.tick && tk.long_sel) |-> (tk.pre == 12'hfff);
  endproperty
  a_long_tick: assert property (p_long_tick) else $error("long step not at full prescale");

  property p_service_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && svc_wr) |=> (cnt_q == 6'h00) && (tk.pre[11:4] == 8'h00);
  endproperty
  a_service_clear: assert property (p_service_clear) else $error("service did not clear");

  property p_vector_read;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && setup && !i_pwrite && hit(i_paddr, `WDT_IDX_SERVICE))
      |=> (o_prdata == {24'h0, $past(i_reset_vector_lo)}) && o_pready;
  endproperty
  a_vector_read: assert property (p_vector_read) else $error("service read not vector");

  property p_cause_set;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && o_sys_rst_req) |=> cause_q[0] ##1 o_rst_pin_oe;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause or pin missing");

  property p_disabled_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && disabled) |=> (cnt_q == 6'h00) && (tk.pre == 12'h000) && !overflow;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("counting while disabled");

  property p_int_reset;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && i_internal_reset) |=> (cnt_q == 6'h00) && (tk.pre == 12'h000);
  endproperty
  a_int_reset: assert property (p_int_reset) else $error("internal reset did not clear");

  property p_stop_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && (i_stop_exec || i_vector_fetch)) |=> (tk.pre == 12'h000);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("prescaler not cleared");

  property p_por_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && por_clr) |=> (tk.pre == 12'h000) && por_done_q;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("power-on clear missing");

  c_overflow: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_sys_rst_req);
  c_service:  cover property (@(posedge i_clk) disable iff (!i_rst_n) svc_wr);
  c_pin_low:  cover property (@(posedge i_clk) disable iff (!i_rst_n) $fell(o_rst_pin_oe));
endmodule // wdt_top

/* test_wdt_top.sv */
// self-checking testbench for the watchdog timeout reset block
`timescale 1ns/1ps
`include "wdt_params.svh"
module test_wdt_top;
  logic                   i_clk;
  logic                   i_rst_n;
  logic                   i_ce;
  logic                   i_psel;
  logic                   i_penable;
  logic                   i_pwrite;
  logic [`WDT_ADDR_W-1:0] i_paddr;
  logic [31:0]            i_pwdata;
  logic [31:0]            o_prdata;
  logic                   o_pready;
  logic                   o_pslverr;
  logic [4:0]             mode;  // monitor, break, reset hv, irq hv, stop mode
  logic                   i_stop_exec;
  logic                   i_internal_reset;
  logic                   i_vector_fetch;
  logic                   o_rst_pin_o;
  logic                   o_rst_pin_oe;
  logic                   o_sys_rst_req;
  logic                   o_irq;
  logic                   rst_pin;
  logic [31:0]            rd;
  logic                   err;
  int                     n;
  int                     num_errors;
  int                     cmp_count;
  localparam logic [7:0]  VEC_LO = 8'h5a;
  // cfg bits [6:5] and mode [4:0] for runs that must stay quiet
  localparam logic [6:0]  QUIET [6] = '{7'h14, 7'h12, 7'h0c, 7'h01, 7'h20, 7'h40};

  // reset pin has a pull-up, low only while the block drives it
  assign rst_pin = o_rst_pin_oe ? o_rst_pin_o : 1'b1;

  wdt_top u_wdt_top (
    .i_clk             (i_clk),
    .i_rst_n           (i_rst_n),
    .i_ce              (i_ce),
    .i_psel            (i_psel),
    .i_penable         (i_penable),
    .i_pwrite          (i_pwrite),
    .i_paddr           (i_paddr),
    .i_pwdata          (i_pwdata),
    .o_prdata          (o_prdata),
    .o_pready          (o_pready),
    .o_pslverr         (o_pslverr),
    .i_reset_vector_lo (VEC_LO),
    .i_monitor_mode    (mode[4]),
    .i_break_state     (mode[3]),
    .i_rst_pin_hv      (mode[2]),
    .i_irq_pin_hv      (mode[1]),
    .i_stop_exec       (i_stop_exec),
    .i_stop_mode       (mode[0]),
    .i_internal_reset  (i_internal_reset),
    .i_vector_fetch    (i_vector_fetch),
    .i_rst_pin_i       (rst_pin),
    .o_rst_pin_o       (o_rst_pin_o),
    .o_rst_pin_oe      (o_rst_pin_oe),
    .o_sys_rst_req     (o_sys_rst_req),
    .o_irq             (o_irq)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one apb transfer; holds everything until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= {idx, 2'b00};
    i_pwdata  <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // no wait-state count assumed; a hang is left to the watchdog process
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd  = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // cycles until a reset request, or lim if none comes
  task automatic wait_req(input int lim);
    n = 0;
    while (o_sys_rst_req !== 1'b1 && n < lim) begin
      @(posedge i_clk);
      n++;
    end
  endtask

  // reset pin must be pulled low for an exact span
  task automatic pulse_chk;
    int k;
    k = 0;
    while (o_rst_pin_oe !== 1'b1 && k < 8) begin
      @(posedge i_clk);
      k++;
    end
    chk(rst_pin, 1'b0);
    n = 0;
    while (o_rst_pin_oe === 1'b1 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    chk(n, 32);
  endtask

  // 200 MHz crystal clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // hang guard, past the ~85k cycles the tests take
  initial begin
    #475000;
    num_errors++;
    results();
  end

  initial begin
    i_rst_n          = 1'b0;
    i_ce             = 1'b1;
    i_psel           = 1'b0;
    i_penable        = 1'b0;
    i_pwrite         = 1'b0;
    i_paddr          = '0;
    i_pwdata         = 32'h0;
    mode             = 5'h0;
    i_stop_exec      = 1'b0;
    i_internal_reset = 1'b0;
    i_vector_fetch   = 1'b0;
    num_errors       = 0;
    cmp_count        = 0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // reset values and plain reads
    apb(1'b0, `WDT_IDX_CFG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `WDT_IDX_CAUSE, 32'h0);
    chk(rd, 32'h0);
    chk(o_irq, 1'b0);
    apb(1'b0, `WDT_IDX_SERVICE, 32'h0);
    chk(rd, {24'h0, VEC_LO});
    apb(1'b0, 16'h0010, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    // let the power-on prescaler clear pass so timing is clean
    repeat (4200) @(posedge i_clk);
    apb(1'b1, `WDT_IDX_IRQ_EN, 32'h3);
    apb(1'b1, `WDT_IDX_SERVICE, 32'hffffffff);
    apb(1'b0, `WDT_IDX_IRQ_STAT, 32'h0);
    chk(rd, 32'h2);
    // unserviced run to the short timeout
    apb(1'b1, `WDT_IDX_SERVICE, 32'h0);
    wait_req(9000);
    chk({31'h0, n >= 8176 && n <= 8200}, 32'h1);
    pulse_chk();
    apb(1'b0, `WDT_IDX_CAUSE, 32'h0);
    chk(rd, 32'h1);
    chk(o_irq, 1'b1);
    // masked status stays sticky but quiet
    apb(1'b1, `WDT_IDX_IRQ_EN, 32'h0);
    apb(1'b0, `WDT_IDX_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    chk(o_irq, 1'b0);
    apb(1'b1, `WDT_IDX_IRQ_CLR, 32'h3);
    apb(1'b1, `WDT_IDX_CAUSE, 32'h1);
    apb(1'b1, `WDT_IDX_IRQ_EN, 32'h3);
    apb(1'b0, `WDT_IDX_CAUSE, 32'h0);
    chk(rd, 32'h0);
    chk(o_irq, 1'b0);
    // internal reset mid-count restarts the full timeout
    apb(1'b1, `WDT_IDX_SERVICE, 32'h0);
    repeat (4000) @(posedge i_clk);
    i_internal_reset <= 1'b1;
    @(posedge i_clk);
    i_internal_reset <= 1'b0;
    wait_req(9000);
    chk({31'h0, n >= 8176 && n <= 8200}, 32'h1);
    pulse_chk();
    // long timeout, disable, monitor, break and stop must all stay quiet
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, `WDT_IDX_CFG, {30'h0, QUIET[c][6:5]});
      mode <= QUIET[c][4:0];
      apb(1'b1, `WDT_IDX_SERVICE, 32'h0);
      i_vector_fetch <= 1'b1;
      i_stop_exec    <= 1'b1;
      @(posedge i_clk);
      i_vector_fetch <= 1'b0;
      i_stop_exec    <= 1'b0;
      wait_req(8500);
      chk(n, 8500);
      // state word: long run has stepped twice, the others sit cleared
      apb(1'b0, `WDT_IDX_STATE, 32'h0);
      if (c == 5) chk({26'h0, rd[5:0]}, 32'h2);
      else if (c == 3) chk(rd, 32'h0080_0000);
      else chk(rd, 32'h00c0_0000);
      mode <= 5'h0;
      apb(1'b1, `WDT_IDX_CFG, 32'h0);
      apb(1'b1, `WDT_IDX_SERVICE, 32'h0);
    end
    // frozen clock enable holds the count; the timeout resumes where it stopped
    apb(1'b1, `WDT_IDX_SERVICE, 32'h0);
    repeat (8000) @(posedge i_clk);
    i_ce <= 1'b0;
    wait_req(400);
    chk(n, 400);
    i_ce <= 1'b1;
    wait_req(400);
    chk({31'h0, n >= 176 && n <= 200}, 32'h1);
    results();
  end
endmodule // test_wdt_top
